/* File: design/sacr_defs.vh */
// register map, field positions and timing constants of the converter control block
`ifndef SACR_DEFS_VH
`define SACR_DEFS_VH

// register offsets on the register port
`define SACR_OFF_CTRL      8'h70
`define SACR_OFF_UPPER     8'h71
`define SACR_OFF_LOWER     8'h72

// control register fields
`define SACR_EOC_BIT       7
`define SACR_SPEED_BIT     6
`define SACR_POWER_BIT     5
`define SACR_RSVD_BIT      4
`define SACR_CHAN_MSB      3
`define SACR_CHAN_LSB      0

// reset values
`define SACR_CTRL_RESET    8'h00
`define SACR_RES_RESET     10'h000
`define SACR_CHAN_RESET    4'h0
`define SACR_BYTE_ZERO     8'h00

// result layout: upper holds bits 9..2, lower holds bits 1..0
`define SACR_RES_MSB       9
`define SACR_UPPER_LSB     2
`define SACR_LOWER_MSB     1
`define SACR_LOWER_PAD     6'h00

// terminal counts of the conversion clock divider, cpu clock divided by four or two
`define SACR_DIV_SLOW      2'h3
`define SACR_DIV_FAST      2'h1
`define SACR_DIV_ZERO      2'h0

// conversion clocks per phase; one sample phase and ten bit trials
`define SACR_PHASE_LAST    1'h1
`define SACR_TOP_BIT       4'h9
`define SACR_LAST_BIT      4'h0
`define SACR_BIT_STEP      4'h1
`define SACR_DAC_ONE       10'h001

`endif

/* File: design/sacr_divider.v */
// conversion clock enable generator, cpu clock divided by four or two
module sacr_divider
(
  // clock and reset
  input  wire       clock,
  input  wire       rst,
  input  wire       ce,
  // control
  input  wire       run,
  input  wire       fast,
  // conversion clock enable, one cpu cycle wide
  output reg        tick
);

`include "sacr_defs.vh"

  reg  [1:0] count;
  wire [1:0] limit;

  // terminal count for the chosen ratio
  assign limit = fast ? `SACR_DIV_FAST : `SACR_DIV_SLOW;

  // free count while running, restarts when the sequencer leaves idle
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      count <= `SACR_DIV_ZERO;
      tick  <= 1'b0;
    end
    else if (ce)
    begin
      if (!run)
      begin
        count <= `SACR_DIV_ZERO;
        tick  <= 1'b0;
      end
      else if (count >= limit)
      begin
        count <= `SACR_DIV_ZERO; // ratio switch mid count never overshoots
        tick  <= 1'b1;
      end
      else
      begin
        count <= count + 2'h1;
        tick  <= 1'b0;
      end
    end
  end

endmodule

/* File: design/sacr_top.v */
// register and sequencing logic of the ten bit successive approximation converter
//
// Notes on behaviour
// - channel change aborts, clears flag, restarts conversion
// - enable bit powers converter and starts conversion
// - wait mode leaves converter untouched
// - halt disables converter; software waits stabilization
// - hardware sets completion flag per conversion
// - upper read or control write clears flag
// - speed bit picks cpu clock by four/two
// - select field picks input by binary value
// - upper result reads result bits nine..two
// - lower result reads bits one..zero, rest zero
// - control resets zero, flag bit read only
// - results reset zero, change only on completion
// - enabled converter converts continuously
// - overrange gives all ones, underrange zero
module sacr_top
(
  // clock, reset and clock enable
  input  wire       clock,
  input  wire       rst,
  input  wire       ce,
  // register port
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_write,
  input  wire       reg_read,
  output reg  [7:0] reg_rdata,
  // low power state of the cpu
  input  wire       halt_mode,
  // analog core
  input  wire       comp_above,
  output reg        analog_power_on,
  output reg  [3:0] analog_input_pin,
  output reg        sample_hold,
  output reg  [9:0] dac_code,
  // status
  output reg        conversion_done
);

`include "sacr_defs.vh"

  // sequencer states
  localparam [1:0] ST_IDLE   = 2'b00;
  localparam [1:0] ST_SAMPLE = 2'b01;
  localparam [1:0] ST_TRIAL  = 2'b10;

  // control register fields
  reg        eoc_flag;
  reg        speed_fast;
  reg        converter_power_enable;
  reg        reserved_bit;
  reg  [3:0] input_select_field;

  // result registers
  reg  [9:0] result_value;

  // sequencer
  reg  [1:0] state;
  reg        phase_count;
  reg  [3:0] bit_index;
  reg  [9:0] trial_code;

  // comparator synchroniser
  reg        comp_meta;
  reg        comp_sync;

  wire       conv_tick;
  wire       wr_ctrl;
  wire       rd_upper;
  wire       chan_change;
  wire       power_rise;
  wire       run;
  wire       abort;
  wire       phase_end;
  wire       finish;
  wire [9:0] bit_mask;
  wire [9:0] kept_code;
  wire [7:0] ctrl_read;
  wire [7:0] upper_read;
  wire [7:0] lower_read;
  reg  [7:0] next_rdata;

  // register port decode
  assign wr_ctrl     = reg_write && (reg_addr == `SACR_OFF_CTRL);
  assign rd_upper    = reg_read && (reg_addr == `SACR_OFF_UPPER);

  // channel change while running restarts the conversion
  assign chan_change = wr_ctrl && converter_power_enable &&
                       (reg_wdata[`SACR_CHAN_MSB:`SACR_CHAN_LSB] != input_select_field);
  assign power_rise  = wr_ctrl && reg_wdata[`SACR_POWER_BIT] && !converter_power_enable;

  // halt forces the converter off; wait mode has no path into this block
  assign run   = converter_power_enable && !halt_mode;
  assign abort = chan_change || power_rise || !run;

  // phase and conversion end
  assign phase_end = conv_tick && (phase_count == `SACR_PHASE_LAST);
  assign finish    = (state == ST_TRIAL) && phase_end && (bit_index == `SACR_LAST_BIT);

  // bit under trial and code after the decision
  assign bit_mask  = `SACR_DAC_ONE << bit_index;
  assign kept_code = comp_sync ? trial_code : (trial_code & ~bit_mask);

  // read views of the three registers
  assign ctrl_read  = {eoc_flag, speed_fast, converter_power_enable, reserved_bit,
                       input_select_field};
  assign upper_read = result_value[`SACR_RES_MSB:`SACR_UPPER_LSB];
  assign lower_read = {`SACR_LOWER_PAD, result_value[`SACR_LOWER_MSB:0]};

  // conversion clock from the cpu clock
  sacr_divider u_divider
  (
    .clock (clock),
    .rst   (rst),
    .ce    (ce),
    .run   (state != ST_IDLE),
    .fast  (speed_fast),
    .tick  (conv_tick)
  );

  // comparator arrives from the analog core, two stages before use
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
    end
    else if (ce)
    begin
      comp_meta <= comp_above;
      comp_sync <= comp_meta;
    end
  end

  // software writable control fields
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      speed_fast             <= 1'b0;
      converter_power_enable <= 1'b0;
      reserved_bit           <= 1'b0;
      input_select_field     <= `SACR_CHAN_RESET;
    end
    else if (ce && wr_ctrl)
    begin
      speed_fast             <= reg_wdata[`SACR_SPEED_BIT];
      converter_power_enable <= reg_wdata[`SACR_POWER_BIT];
      reserved_bit           <= reg_wdata[`SACR_RSVD_BIT]; // kept as written, no function
      input_select_field     <= reg_wdata[`SACR_CHAN_MSB:`SACR_CHAN_LSB];
    end
  end

  // completion flag: set by hardware, wins over a same cycle clear
  always @(posedge clock or posedge rst)
  begin
    if (rst)
      eoc_flag <= 1'b0;
    else if (ce)
    begin
      if (finish && !abort)
        eoc_flag <= 1'b1;
      else if (rd_upper || wr_ctrl)
        eoc_flag <= 1'b0;
    end
  end

  // results move only on a finished conversion, together with the flag
  always @(posedge clock or posedge rst)
  begin
    if (rst)
      result_value <= `SACR_RES_RESET;
    else if (ce && finish && !abort)
      result_value <= kept_code;
  end

  // conversion sequencer
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state       <= ST_IDLE;
      phase_count <= 1'b0;
      bit_index   <= `SACR_TOP_BIT;
      trial_code  <= `SACR_RES_RESET;
    end
    else if (ce)
    begin
      if (abort)
      begin
        state       <= ST_IDLE;
        phase_count <= 1'b0;
        bit_index   <= `SACR_TOP_BIT;
        trial_code  <= `SACR_RES_RESET;
      end
      else
      begin
        case (state)
          ST_IDLE:
          begin
            state       <= ST_SAMPLE;
            phase_count <= 1'b0;
          end
          ST_SAMPLE:
          begin
            if (conv_tick)
              phase_count <= ~phase_count;
            if (phase_end)
            begin
              state      <= ST_TRIAL;
              bit_index  <= `SACR_TOP_BIT;
              trial_code <= `SACR_DAC_ONE << `SACR_TOP_BIT;
            end
          end
          ST_TRIAL:
          begin
            if (conv_tick)
              phase_count <= ~phase_count;
            if (phase_end)
            begin
              if (bit_index == `SACR_LAST_BIT)
              begin
                state      <= ST_SAMPLE;
                bit_index  <= `SACR_TOP_BIT;
                trial_code <= `SACR_RES_RESET;
              end
              else
              begin
                bit_index  <= bit_index - `SACR_BIT_STEP;
                trial_code <= kept_code | (bit_mask >> 1);
              end
            end
          end
          default:
            state <= ST_IDLE;
        endcase
      end
    end
  end

  // drive of the analog core
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      analog_power_on  <= 1'b0;
      analog_input_pin <= `SACR_CHAN_RESET;
      sample_hold      <= 1'b0;
      dac_code         <= `SACR_RES_RESET;
      conversion_done  <= 1'b0;
    end
    else if (ce)
    begin
      analog_power_on  <= run;
      analog_input_pin <= input_select_field;
      sample_hold      <= (state == ST_SAMPLE) && !abort;
      dac_code         <= trial_code;
      conversion_done  <= finish && !abort;
    end
  end

  // read mux, unmapped offsets read zero
  always @*
  begin
    next_rdata = `SACR_BYTE_ZERO;
    if (reg_addr == `SACR_OFF_CTRL)
      next_rdata = ctrl_read;
    else if (reg_addr == `SACR_OFF_UPPER)
      next_rdata = upper_read;
    else if (reg_addr == `SACR_OFF_LOWER)
      next_rdata = lower_read;
  end

  // read data stand one cycle after the strobe, else zero
  always @(posedge clock or posedge rst)
  begin
    if (rst)
      reg_rdata <= `SACR_BYTE_ZERO;
    else if (ce)
      reg_rdata <= reg_read ? next_rdata : `SACR_BYTE_ZERO;
  end

endmodule

/* File: verification/sacr_analog.sv */
// behavioural sample and hold with comparator of the analog core
module sacr_analog
(
  // clock
  input wire logic       clock,
  // from the control block
  input wire logic       analog_power_on,
  input wire logic [3:0] analog_input_pin,
  input wire logic       sample_hold,
  input wire logic [9:0] dac_code,
  // comparator
  output logic           comp_above
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] held = 10'h000;
  logic       tog  = 1'b0;
  // input 15 sits above the upper reference, so full scale
  always @(posedge clock)
  begin
    tog <= ~tog;
    if (sample_hold)
      held <= analog_input_pin == 4'hF ? 10'h3FF : {analog_input_pin, 6'h15};
  end
  // unpowered comparator output is garbage
  assign comp_above = analog_power_on ? (held >= dac_code) : tog;
endmodule

/* File: verification/sacr_sva.sv */
// checker of the converter control block ports
`include "sacr_defs.vh"
module sacr_sva
(
  // clock and reset
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       ce,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  // core side
  input wire logic       halt_mode,
  input wire logic       comp_above,
  input wire logic       analog_power_on,
  input wire logic [3:0] analog_input_pin,
  input wire logic       sample_hold,
  input wire logic [9:0] dac_code,
  input wire logic       conversion_done
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // register port answers
  a_lower_pad: assert property (ce && reg_read && reg_addr == `SACR_OFF_LOWER
    |=> reg_rdata[7:2] == 6'h00) else $error("lower pad bits set");
  a_read_idle: assert property (ce && !reg_read |=> reg_rdata == 8'h00)
    else $error("read data outside read");
  // completion flag; a clear in the done cycle would legally drop it
  a_flag_set: assert property (conversion_done && !reg_write && !reg_read
    ##1 reg_read && reg_addr == `SACR_OFF_CTRL |=> reg_rdata[7]) else $error("flag missing");
  a_flag_clear: assert property (reg_write && reg_addr == `SACR_OFF_CTRL
    ##1 !conversion_done ##1 reg_read && reg_addr == `SACR_OFF_CTRL && !conversion_done
    |=> !reg_rdata[7]) else $error("flag kept after write");
  a_upper_clear: assert property (reg_read && reg_addr == `SACR_OFF_UPPER
    ##1 !conversion_done ##1 reg_read && reg_addr == `SACR_OFF_CTRL && !conversion_done
    |=> !reg_rdata[7]) else $error("flag kept after upper read");
  // power and channel
  a_halt_off: assert property (halt_mode [*3] |-> !analog_power_on && !conversion_done)
    else $error("converter active in halt");
  a_power_on: assert property (reg_write && reg_addr == `SACR_OFF_CTRL && reg_wdata[5]
    && !halt_mode ##1 !halt_mode |=> analog_power_on) else $error("no power up");
  a_power_idle: assert property (!analog_power_on [*4] |-> !sample_hold
    && !conversion_done) else $error("activity while off");
  a_pin_follow: assert property (ce && reg_write && reg_addr == `SACR_OFF_CTRL
    |=> ##1 analog_input_pin == $past(reg_wdata[3:0], 2)) else $error("pin mismatch");
  a_done_space: assert property (conversion_done |=> !conversion_done [*8])
    else $error("completions too close");
  // main scenarios
  c_done: cover property (conversion_done);
  c_wake: cover property (halt_mode ##1 !halt_mode);
  c_upper: cover property (reg_read && reg_addr == `SACR_OFF_UPPER);
endmodule

bind sacr_top sacr_sva u_sva (.clock, .rst, .ce, .reg_addr, .reg_wdata, .reg_write,
  .reg_read, .reg_rdata, .halt_mode, .comp_above, .analog_power_on, .analog_input_pin,
  .sample_hold, .dac_code, .conversion_done);

/* File: verification/tb_top.sv */
// self-checking bench of the converter control block
`include "sacr_defs.vh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_write = 1'b0;
  logic       reg_read = 1'b0;
  logic       halt_mode = 1'b0;
  logic [7:0] reg_rdata;
  logic       comp_above, analog_power_on, sample_hold, conversion_done;
  logic [3:0] analog_input_pin;
  logic [9:0] dac_code, r;
  int         num_errors = 0, checks = 0, cyc = 0, n, i;
  logic [3:0] rch [4] = '{4'h3, 4'h9, 4'hF, 4'h0};
  logic       rsp [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  // cpu clock, 40 ns
  always #20 clock = ~clock;
  sacr_top u_dut (.clock(clock), .rst(rst), .ce(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .halt_mode(halt_mode), .comp_above(comp_above),
    .analog_power_on(analog_power_on), .analog_input_pin(analog_input_pin),
    .sample_hold(sample_hold), .dac_code(dac_code), .conversion_done(conversion_done));
  sacr_analog u_ana (.clock(clock), .analog_power_on(analog_power_on),
    .analog_input_pin(analog_input_pin), .sample_hold(sample_hold),
    .dac_code(dac_code), .comp_above(comp_above));
  // value the core presents on an input
  function automatic [9:0] lvl(input [3:0] c);
    lvl = c == 4'hF ? 10'h3FF : {c, 6'h15};
  endfunction
  // one-cycle register write
  task wr(input [7:0] a, input [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  // read, data compared in the following cycle
  task rd(input [7:0] a, input [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    `CHK("rdata", e, reg_rdata)
  endtask
  // cycles to the next completion, 150 when none
  task wdone(output int k);
    k = 0;
    do
    begin
      @(posedge clock);
      #1;
      k++;
    end
    while (k < 150 && conversion_done !== 1'b1);
  endtask
  task end_sim;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      end_sim();
    end
  end
  // main sequence
  initial
  begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    rd(`SACR_OFF_CTRL, 8'h00);
    rd(`SACR_OFF_UPPER, 8'h00);
    rd(`SACR_OFF_LOWER, 8'h00);
    rd(8'h73, 8'h00);
    wr(`SACR_OFF_UPPER, 8'hFF);
    rd(`SACR_OFF_UPPER, 8'h00);
    wr(`SACR_OFF_CTRL, 8'h80);
    rd(`SACR_OFF_CTRL, 8'h00);
    wdone(n);
    `CHK("idle", 150, n)
    // channel and speed rows, bit 4 always written zero
    for (i = 0; i < 4; i++)
    begin
      wr(`SACR_OFF_CTRL, {1'b0, rsp[i], 2'b10, rch[i]});
      wdone(n);
      wdone(n);
      `CHK("period", rsp[i] ? 44 : 88, n)
      r = lvl(rch[i]);
      rd(`SACR_OFF_CTRL, {1'b1, rsp[i], 2'b10, rch[i]});
      rd(`SACR_OFF_LOWER, {6'h00, r[1:0]});
      rd(`SACR_OFF_UPPER, r[9:2]);
      rd(`SACR_OFF_CTRL, {1'b0, rsp[i], 2'b10, rch[i]});
    end
    wdone(n);
    wr(`SACR_OFF_CTRL, 8'h60);
    rd(`SACR_OFF_CTRL, 8'h60);
    rd(`SACR_OFF_UPPER, 8'h05);
    // channel change in mid conversion
    wr(`SACR_OFF_CTRL, 8'h63);
    repeat (20) @(posedge clock);
    wr(`SACR_OFF_CTRL, 8'h67);
    rd(`SACR_OFF_CTRL, 8'h67);
    wdone(n);
    r = lvl(4'h7);
    rd(`SACR_OFF_UPPER, r[9:2]);
    // halt and wake
    @(posedge clock);
    halt_mode <= 1'b1;
    wdone(n);
    `CHK("halt", 150, n)
    halt_mode <= 1'b0;
    wdone(n);
    `CHK("wake", 1'b1, n < 150)
    // switch off just after a completion, with the next conversion running
    wr(`SACR_OFF_CTRL, 8'h00);
    wdone(n);
    `CHK("off", 150, n)
    `CHK("power", 1'b0, analog_power_on)
    end_sim();
  end
endmodule
